//--- common/rmbp_pkg.sv
// Package with constants and types shared by both ends of the multiplexed RTC bus
`default_nettype none

package rmbp_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  // Half period of slow clock, rounded down to whole cycles
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned CLEAR_MS = 125;
  localparam int unsigned CLEAR_CYC = CLK_HZ / 1000 * CLEAR_MS;
  localparam int unsigned CLOCK_REGS = 14;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned UPPER_BYTES = 128;
  localparam logic [7:0] ADDR_REG_B = 8'h0b;
  localparam logic [7:0] ADDR_REG_C = 8'h0c;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Register B enable bits and register C flag bits
  localparam int unsigned BIT_UPD = 4;
  localparam int unsigned BIT_ALM = 5;
  localparam int unsigned BIT_PER = 6;
  localparam int unsigned BIT_SUM = 7;
  localparam logic [7:0] ENABLE_MASK = 8'h70;
  // Host bus state, Gray coded
  typedef enum logic [1:0] {
    RMBP_IDLE = 2'b00,
    RMBP_ADDR = 2'b01,
    RMBP_DATA = 2'b11,
    RMBP_DONE = 2'b10
  } rmbp_state_e;
endpackage : rmbp_pkg

`default_nettype wire

//--- common/rmbp_if.sv
// Interface carrying the multiplexed bus pins between host and RTC
`default_nettype none

interface rmbp_if;
  logic bus_type_select;
  logic addr_latch_strobe;
  logic data_strobe;
  logic rw_dir;
  logic cs_n;
  logic upper_ram_select;
  logic [7:0] host_ad_out;
  logic host_ad_oe;
  logic [7:0] dev_ad_out;
  logic dev_ad_oe;
  logic int_n_oe;
  logic rst_pin_n;
  logic slow_clock_out;
  // Resolved shared lines: pull-ups where nobody drives
  logic [7:0] mux_addr_data;
  logic irq_n;
  assign mux_addr_data = host_ad_oe ? host_ad_out : (dev_ad_oe ? dev_ad_out : 8'hff);
  assign irq_n = ~int_n_oe;

  modport host (
    output bus_type_select, addr_latch_strobe, data_strobe, rw_dir, cs_n,
    output upper_ram_select, host_ad_out, host_ad_oe, rst_pin_n,
    input mux_addr_data, irq_n, slow_clock_out
  );
  modport device (
    input bus_type_select, addr_latch_strobe, data_strobe, rw_dir, cs_n,
    input upper_ram_select, mux_addr_data, rst_pin_n,
    output dev_ad_out, dev_ad_oe, int_n_oe, slow_clock_out
  );
endinterface : rmbp_if

`default_nettype wire

//--- rtl/rmbp_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module rmbp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [W-1:0] pin_in, // Asynchronous pins
  output logic [W-1:0] level_out // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // First stage feeds only the second, so no logic sees a metastable value
  always_ff @(posedge clock) begin
    s1_reg <= pin_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // A change counts once the later stages agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : rmbp_sync

`default_nettype wire

//--- rtl/rmbp_device.sv
// RTC end of the multiplexed bus: address latch, strobes, storage, interrupt
`default_nettype none

module rmbp_device (
  input wire logic clock, // 125 MHz system clock
  input wire logic rst_n, // Synchronous reset of this logic
  rmbp_if.device bus, // Pin side
  input wire logic storage_clear_n, // Pushbutton clear, active low
  input wire logic supply_valid, // Main supply present
  input wire logic [2:0] event_pulse, // Update, alarm, periodic events
  output logic [7:0] enables_out // Register B image
);
  // Sync order: 0 as,1 ds,2 rw,3 cs_n,4 ext,5 clear_n,6 rst pin,7 strap
  logic [7:0] raw;
  logic [7:0] syn;
  logic [7:0] ad_syn;
  assign raw = {bus.bus_type_select, bus.rst_pin_n, storage_clear_n, bus.upper_ram_select,
                bus.cs_n, bus.rw_dir, bus.data_strobe, bus.addr_latch_strobe};

  rmbp_sync #(.W(8)) u_ctl (.clock(clock), .rst_n(rst_n), .pin_in(raw), .level_out(syn));
  rmbp_sync #(.W(8)) u_ad (.clock(clock), .rst_n(rst_n), .pin_in(bus.mux_addr_data),
                           .level_out(ad_syn));

  logic as_d, ds_d, rw_d;
  logic level_mode;
  logic pin_rst;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      as_d <= 1'b0;
      ds_d <= 1'b0;
      rw_d <= 1'b1;
    end else begin
      as_d <= syn[0];
      ds_d <= syn[1];
      rw_d <= syn[2];
    end
  end
  assign level_mode = syn[7];
  assign pin_rst = ~syn[6];

  logic as_fall, ds_rise, ds_fall, rw_rise;
  assign as_fall = as_d & ~syn[0];
  assign ds_rise = ~ds_d & syn[1];
  assign ds_fall = ds_d & ~syn[1];
  assign rw_rise = ~rw_d & syn[2];

  // Address latch independent of chip select
  logic [8:0] addr_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_reg <= '0;
    end else if (as_fall) begin
      addr_reg <= {syn[4], ad_syn};
    end
  end

  // Storage: 256 lower bytes (clock regs at bottom) and 128 upper bytes
  logic [7:0] mem_reg [rmbp_pkg::MEM_BYTES + rmbp_pkg::UPPER_BYTES];
  logic [7:0] flags_reg;
  function automatic logic [8:0] mem_index(input logic [8:0] a);
    mem_index = a[8] ? (9'(rmbp_pkg::MEM_BYTES) + {2'b00, a[6:0]}) : {1'b0, a[7:0]};
  endfunction : mem_index

  logic sel;
  logic read_c_ev;
  logic wr_ev;
  logic rd_start;
  assign sel = ~syn[3] & ~pin_rst;
  assign wr_ev = sel & (level_mode ? (ds_fall & ~syn[2]) : rw_rise);
  assign rd_start = sel & (level_mode ? (ds_rise & syn[2]) : ds_fall);
  assign read_c_ev = rd_start & ~addr_reg[8] & (addr_reg[7:0] == rmbp_pkg::ADDR_REG_C);

  // Clear request timer: held low for the full time while supply valid
  logic [31:0] clr_cnt_reg;
  logic clr_fire;
  always_ff @(posedge clock) begin
    if (!rst_n || syn[5] || !supply_valid) begin
      clr_cnt_reg <= '0;
    end else if (clr_cnt_reg < rmbp_pkg::CLEAR_CYC) begin
      clr_cnt_reg <= clr_cnt_reg + 32'h1;
    end
  end
  assign clr_fire = (clr_cnt_reg == rmbp_pkg::CLEAR_CYC - 1);

  // Byte storage; clock registers are kept out of the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < rmbp_pkg::CLOCK_REGS; i++) begin
        mem_reg[i] <= rmbp_pkg::RESET_BYTE;
      end
    end else if (clr_fire) begin
      for (int i = rmbp_pkg::CLOCK_REGS; i < rmbp_pkg::MEM_BYTES; i++) begin
        mem_reg[i] <= rmbp_pkg::ERASED_BYTE;
      end
    end else if (pin_rst) begin
      mem_reg[rmbp_pkg::ADDR_REG_B] <= mem_reg[rmbp_pkg::ADDR_REG_B] & ~rmbp_pkg::ENABLE_MASK;
    end else if (wr_ev && supply_valid) begin
      mem_reg[mem_index(addr_reg)] <= ad_syn;
    end
  end
  // Pin reset tied high leaves control bits alone

  // Event flags: set beats the clear from a register C read
  logic any_req;
  always_ff @(posedge clock) begin
    if (!rst_n || pin_rst) begin
      flags_reg <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (event_pulse[i]) begin
          flags_reg[rmbp_pkg::BIT_UPD + i] <= 1'b1;
        end else if (read_c_ev) begin
          flags_reg[rmbp_pkg::BIT_UPD + i] <= 1'b0;
        end
      end
      if (any_req) begin
        flags_reg[rmbp_pkg::BIT_SUM] <= 1'b1;
      end else if (read_c_ev) begin
        flags_reg[rmbp_pkg::BIT_SUM] <= 1'b0;
      end
    end
  end
  assign any_req = |(event_pulse & mem_reg[rmbp_pkg::ADDR_REG_B][6:4]);

  // Interrupt drive, released by a register C read
  always_ff @(posedge clock) begin
    if (!rst_n || pin_rst) begin
      bus.int_n_oe <= 1'b0;
    end else if (any_req) begin
      bus.int_n_oe <= 1'b1;
    end else if (read_c_ev) begin
      bus.int_n_oe <= 1'b0;
    end
  end

  // Data drive: starts on read edge, stops when strobe or select ends
  logic rd_end;
  assign rd_end = syn[3] | pin_rst | (level_mode ? ~syn[1] : syn[1]);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus.dev_ad_oe <= 1'b0;
      bus.dev_ad_out <= '0;
    end else if (rd_start) begin
      bus.dev_ad_oe <= 1'b1;
      bus.dev_ad_out <= (!addr_reg[8] && addr_reg[7:0] == rmbp_pkg::ADDR_REG_C)
                      ? flags_reg : mem_reg[mem_index(addr_reg)];
    end else if (rd_end) begin
      bus.dev_ad_oe <= 1'b0;
    end
  end

  // Slow clock divider; the modelled time base stands for the crystal
  logic [11:0] div_reg;
  always_ff @(posedge clock) begin
    if (!rst_n || !supply_valid) begin
      div_reg <= '0;
      bus.slow_clock_out <= 1'b0;
    end else if (div_reg == 12'(rmbp_pkg::SLOW_HALF_CYC - 1)) begin
      div_reg <= '0;
      bus.slow_clock_out <= ~bus.slow_clock_out;
    end else begin
      div_reg <= div_reg + 12'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enables_out <= '0;
    end else begin
      enables_out <= mem_reg[rmbp_pkg::ADDR_REG_B];
    end
  end
endmodule : rmbp_device

`default_nettype wire

//--- rtl/rmbp_host.sv
// Host end: runs one read or write cycle on the multiplexed bus
`default_nettype none

module rmbp_host (
  input wire logic clock, // 125 MHz system clock
  input wire logic rst_n, // Synchronous reset
  rmbp_if.host bus, // Pin side
  input wire logic level_mode, // Strap level to present
  input wire logic req, // Start a cycle, one-cycle pulse
  input wire logic req_write, // 1 write, 0 read
  input wire logic [8:0] req_addr, // Bit 8 upper bank select
  input wire logic [7:0] req_wdata, // Write data
  output logic busy, // Cycle in progress
  output logic done, // Pulse at cycle end
  output logic [7:0] rdata, // Read data
  output logic irq // Interrupt seen
);
  localparam logic [4:0] PHASE = 5'h08; // Cycles per phase, covers device sync delay
  rmbp_pkg::rmbp_state_e state_reg;
  logic [4:0] cnt_reg;
  logic wr_reg;
  logic [8:0] addr_reg;
  logic [7:0] wd_reg;
  logic [1:0] irq_sync;
  logic [7:0] ad_s1, ad_s2;

  always_ff @(posedge clock) begin
    ad_s1 <= bus.mux_addr_data;
    ad_s2 <= ad_s1;
    irq_sync <= {irq_sync[0], ~bus.irq_n};
  end

  // Strobe levels per mode: strap fixed by the level_mode input
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= rmbp_pkg::RMBP_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      irq <= 1'b0;
      bus.bus_type_select <= 1'b0;
      bus.addr_latch_strobe <= 1'b0;
      bus.data_strobe <= 1'b0;
      bus.rw_dir <= 1'b1;
      bus.cs_n <= 1'b1;
      bus.upper_ram_select <= 1'b0;
      bus.host_ad_out <= '0;
      bus.host_ad_oe <= 1'b0;
      bus.rst_pin_n <= 1'b0;
    end else begin
      irq <= irq_sync[1];
      done <= 1'b0;
      bus.rst_pin_n <= 1'b1;
      bus.bus_type_select <= level_mode;
      cnt_reg <= cnt_reg + 5'h1;
      case (state_reg)
        rmbp_pkg::RMBP_IDLE: begin
          bus.data_strobe <= ~level_mode;
          bus.rw_dir <= 1'b1;
          if (req) begin
            wr_reg <= req_write;
            addr_reg <= req_addr;
            wd_reg <= req_wdata;
            busy <= 1'b1;
            bus.addr_latch_strobe <= 1'b1;
            bus.host_ad_out <= req_addr[7:0];
            bus.host_ad_oe <= 1'b1;
            bus.upper_ram_select <= req_addr[8];
            cnt_reg <= '0;
            state_reg <= rmbp_pkg::RMBP_ADDR;
          end
        end
        rmbp_pkg::RMBP_ADDR: begin
          if (cnt_reg == PHASE) begin
            bus.addr_latch_strobe <= 1'b0;
          end
          if (cnt_reg == 2 * PHASE) begin
            bus.cs_n <= 1'b0;
            bus.host_ad_oe <= wr_reg;
            bus.host_ad_out <= wd_reg;
            bus.rw_dir <= level_mode ? ~wr_reg : 1'b1;
            cnt_reg <= '0;
            state_reg <= rmbp_pkg::RMBP_DATA;
          end
        end
        rmbp_pkg::RMBP_DATA: begin
          if (cnt_reg == 5'h1) begin
            if (level_mode) begin
              bus.data_strobe <= 1'b1;
            end else if (wr_reg) begin
              bus.rw_dir <= 1'b0;
            end else begin
              bus.data_strobe <= 1'b0;
            end
          end
          if (cnt_reg == PHASE + PHASE) begin
            if (!wr_reg) begin
              rdata <= ad_s2;
            end
            if (level_mode) begin
              bus.data_strobe <= 1'b0;
            end else begin
              bus.data_strobe <= 1'b1;
              bus.rw_dir <= 1'b1;
            end
            cnt_reg <= '0;
            state_reg <= rmbp_pkg::RMBP_DONE;
          end
        end
        rmbp_pkg::RMBP_DONE: begin
          if (cnt_reg == PHASE) begin
            bus.cs_n <= 1'b1;
            bus.host_ad_oe <= 1'b0;
            bus.upper_ram_select <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_reg <= rmbp_pkg::RMBP_IDLE;
          end
        end
        default: begin
          state_reg <= rmbp_pkg::RMBP_IDLE;
        end
      endcase
    end
  end
endmodule : rmbp_host

`default_nettype wire

//--- tb/rmbp_props.sv
// Checker for the pins between the host and device ends
`default_nettype none

module rmbp_props (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic bus_type_select, // Strap level
  input wire logic addr_latch_strobe, // Address strobe
  input wire logic data_strobe, // Data or read strobe
  input wire logic rw_dir, // Direction or write strobe
  input wire logic cs_n, // Chip select
  input wire logic upper_ram_select, // Upper bank select
  input wire logic host_ad_oe, // Host drives lines
  input wire logic dev_ad_oe, // Device drives lines
  input wire logic int_n_oe, // Device pulls irq low
  input wire logic [7:0] mux_addr_data // Resolved lines
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Remember whether the latched address is register C in bank 0
  logic rdc_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdc_reg <= 1'b0;
    end else if ($fell(addr_latch_strobe)) begin
      rdc_reg <= (mux_addr_data == rmbp_pkg::ADDR_REG_C) && !upper_ram_select;
    end
  end

  // Sync lag in the device is 4 cycles, so windows allow 6
  bus_no_clash_a: assert property (!(host_ad_oe && dev_ad_oe))
    else $error("both ends drive the shared lines");
  cs_hold_a: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("chip select not held through data phase");
  addr_phase_a: assert property ($fell(addr_latch_strobe) |-> cs_n && host_ad_oe)
    else $error("address phase not driven by host");
  lvl_read_a: assert property ($rose(dev_ad_oe) && bus_type_select |-> rw_dir && data_strobe && !cs_n)
    else $error("level mode drive without read strobe");
  split_read_a: assert property ($rose(dev_ad_oe) && !bus_type_select |-> !data_strobe && !cs_n)
    else $error("split mode drive without read strobe");
  read_drive_a: assert property ($rose(data_strobe) && bus_type_select && rw_dir |-> ##[1:6] dev_ad_oe)
    else $error("level mode read not driven");
  split_drive_a: assert property ($fell(data_strobe) && !bus_type_select && !cs_n |-> ##[1:6] dev_ad_oe)
    else $error("split mode read not driven");
  strobe_stop_a: assert property ($fell(data_strobe) && bus_type_select |-> ##[1:6] !dev_ad_oe)
    else $error("drive kept after strobe ended");
  select_stop_a: assert property ($rose(cs_n) |-> !dev_ad_oe)
    else $error("drive kept after deselect");
  irq_release_a: assert property ($rose(cs_n) && rdc_reg && !host_ad_oe |-> !int_n_oe)
    else $error("interrupt held after status read");

  cover property ($rose(dev_ad_oe) && bus_type_select);
  cover property ($rose(dev_ad_oe) && !bus_type_select);
  cover property ($fell(int_n_oe));
endmodule : rmbp_props

`default_nettype wire

//--- tb/tb_rtc_mux_bus_host_port.sv
// Self-checking bench joining host and device ends
`default_nettype none

module tb_rtc_mux_bus_host_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic level_mode = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [8:0] req_addr = 9'h000;
  logic [7:0] req_wdata = 8'h00;
  logic busy, done, irq;
  logic [7:0] rdata, enables_out, v;
  logic storage_clear_n = 1'b1;
  logic supply_valid = 1'b1;
  logic [2:0] event_pulse = 3'h0;
  int bad_count = 0;
  int check_count = 0;

  rmbp_if rif ();
  rmbp_host rmbp_host_inst (.clock(clock), .rst_n(rst_n), .bus(rif), .level_mode(level_mode),
    .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .rdata(rdata), .irq(irq));
  rmbp_device rmbp_device_inst (.clock(clock), .rst_n(rst_n), .bus(rif),
    .storage_clear_n(storage_clear_n), .supply_valid(supply_valid),
    .event_pulse(event_pulse), .enables_out(enables_out));
  rmbp_props rmbp_props_inst (.clock(clock), .rst_n(rst_n),
    .bus_type_select(rif.bus_type_select), .addr_latch_strobe(rif.addr_latch_strobe),
    .data_strobe(rif.data_strobe), .rw_dir(rif.rw_dir), .cs_n(rif.cs_n),
    .upper_ram_select(rif.upper_ram_select), .host_ad_oe(rif.host_ad_oe),
    .dev_ad_oe(rif.dev_ad_oe), .int_n_oe(rif.int_n_oe), .mux_addr_data(rif.mux_addr_data));

  // 125 MHz clock
  initial begin
    forever #4 clock = ~clock;
  end

  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One host cycle; inputs change at the falling edge only
  task automatic bus_op(input logic wr, input logic [8:0] addr, input logic [7:0] wd,
      output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clock);
    req_write = wr;
    req_addr = addr;
    req_wdata = wd;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    rd = rdata;
  endtask : bus_op

  task automatic rd_chk(input logic [8:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    bus_op(1'b0, addr, 8'h00, got);
    chk("rdata", exp, got);
  endtask : rd_chk

  // Both strap modes, back-to-back write then reads
  task automatic t_modes();
    for (int m = 0; m < 2; m++) begin
      // Strap only moves while the ends are held in reset
      rst_n = 1'b0;
      level_mode = m[0];
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (10) @(negedge clock);
      bus_op(1'b1, 9'h020, 8'h5a ^ m[7:0], v);
      bus_op(1'b1, 9'h021, 8'ha5, v);
      rd_chk(9'h020, 8'h5a ^ m[7:0]);
      rd_chk(9'h021, 8'ha5);
    end
  endtask : t_modes

  // Upper bank is a separate store
  task automatic t_upper();
    bus_op(1'b1, 9'h120, 8'hc3, v);
    rd_chk(9'h020, 8'h5b);
    rd_chk(9'h120, 8'hc3);
  endtask : t_upper

  // Enabled event, status read clears, then masked event
  task automatic t_irq();
    bus_op(1'b1, 9'h00b, rmbp_pkg::ENABLE_MASK, v);
    chk("enables", 8'h70, enables_out);
    @(negedge clock);
    event_pulse = 3'h2;
    @(negedge clock);
    event_pulse = 3'h0;
    repeat (10) @(negedge clock);
    chk("irq", 8'h01, {7'h00, irq});
    rd_chk(9'h00c, 8'ha0);
    repeat (6) @(negedge clock);
    chk("irq", 8'h00, {7'h00, irq});
    rd_chk(9'h00c, 8'h00);
    bus_op(1'b1, 9'h00b, 8'h00, v);
    event_pulse = 3'h4;
    @(negedge clock);
    event_pulse = 3'h0;
    repeat (10) @(negedge clock);
    chk("irq", 8'h00, {7'h00, irq});
    rd_chk(9'h00c, 8'h40);
  endtask : t_irq

  // Writes refused while supply is missing
  task automatic t_power();
    supply_valid = 1'b0;
    bus_op(1'b1, 9'h020, 8'h00, v);
    supply_valid = 1'b1;
    rd_chk(9'h020, 8'h5b);
    // A short press of the clear pin must leave storage alone
    storage_clear_n = 1'b0;
    repeat (200) @(negedge clock);
    storage_clear_n = 1'b1;
    rd_chk(9'h020, 8'h5b);
  endtask : t_power

  // Half period of the slow clock, counted in falling edges
  task automatic t_slow();
    int n;
    logic s;
    n = 0;
    s = rif.slow_clock_out;
    while (rif.slow_clock_out === s && n < 5000) begin
      @(negedge clock);
      n++;
    end
    s = rif.slow_clock_out;
    n = 0;
    while (rif.slow_clock_out === s && n < 5000) begin
      @(negedge clock);
      n++;
    end
    check_count++;
    if (n != int'(rmbp_pkg::SLOW_HALF_CYC)) begin
      bad_count++;
      $display("MISMATCH slow_half expected %0d seen %0d", rmbp_pkg::SLOW_HALF_CYC, n);
    end
  endtask : t_slow

  // Mid-run reset clears enables and floats the interrupt
  task automatic t_reset();
    bus_op(1'b1, 9'h00b, 8'h70, v);
    event_pulse = 3'h1;
    @(negedge clock);
    event_pulse = 3'h0;
    rst_n = 1'b0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    chk("enables", 8'h00, enables_out);
    chk("irq", 8'h00, {7'h00, irq});
    rd_chk(9'h00c, 8'h00);
  endtask : t_reset

  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    t_modes();
    t_upper();
    t_irq();
    t_power();
    t_slow();
    t_reset();
    end_of_test();
  end

  // Watchdog: the run needs well under 20000 cycles
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_rtc_mux_bus_host_port

`default_nettype wire
